/* ostc_pkg.sv */
// Package for the oscillator status and tuning block: offsets, fields, reset values
package ostc_pkg;
    // Register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] OSTC_OFF_REQ    = 8'h00;
    localparam logic [7:0] OSTC_OFF_STATUS = 8'h04;
    localparam logic [7:0] OSTC_OFF_CTRL   = 8'h08;
    localparam logic [7:0] OSTC_OFF_READY  = 8'h0C;
    localparam logic [7:0] OSTC_OFF_FREQ   = 8'h10;
    localparam logic [7:0] OSTC_OFF_TRIM   = 8'h14;

    // Field positions
    localparam int OSTC_SRC_LSB  = 4;
    localparam int OSTC_HOLD_BIT = 7;
    localparam int OSTC_PWR_BIT  = 6;
    localparam int OSTC_OSC_READY_BIT = 4;
    localparam int OSTC_NRDY_BIT = 3;

    // Source encodings
    localparam logic [2:0] OSTC_SRC_EXT    = 3'h7;
    localparam logic [2:0] OSTC_SRC_HF     = 3'h6;
    localparam logic [2:0] OSTC_SRC_LF     = 3'h5;
    localparam logic [2:0] OSTC_SRC_SEC    = 3'h4;
    localparam logic [2:0] OSTC_SRC_EXTPLL = 3'h2;
    localparam logic [2:0] OSTC_SRC_ZERO   = 3'h0;

    // Divider encodings and limit
    localparam logic [3:0] OSTC_DIV_1   = 4'h0;
    localparam logic [3:0] OSTC_DIV_4   = 4'h2;
    localparam logic [3:0] OSTC_DIV_MAX = 4'h9;

    // Frequency codes
    localparam logic [3:0] OSTC_FRQ_4M  = 4'h2;
    localparam logic [3:0] OSTC_FRQ_64M = 4'h8;
    localparam logic [3:0] OSTC_FRQ_MAX = 4'h8;

    localparam logic [5:0] OSTC_TRIM_RST = 6'h00;

    // Ready vector index: 7 ext, 6 hf, 5 mf, 4 lf, 3 sec, 2 conv, 0 pll
    localparam int OSTC_NRDY = 8;

    typedef enum logic [2:0] {
        OSTC_IDLE = 3'b001,
        OSTC_WAIT = 3'b010,
        OSTC_SWAP = 3'b100
    } ostc_state_t;
endpackage : ostc_pkg

/* ostc_top.sv */
// Oscillator status, switch control, frequency select and trim registers
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ostc_top
    import ostc_pkg::*;
(
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [2:0]           reset_source_code,
    input  wire logic [OSTC_NRDY-1:0] osc_ready_raw,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    output logic [1:0]                s_axi_bresp,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    input  wire logic [7:0]           s_axi_araddr,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      switch_event,
    output logic                      secondary_osc_power,
    output logic [2:0]                current_source,
    output logic [3:0]                current_divider,
    output logic [3:0]                internal_freq_code,
    output logic [5:0]                trim_code
);
    logic [2:0]           requested_source_q;
    logic [3:0]           requested_divider_q;
    logic [2:0]           current_source_q;
    logic [3:0]           current_divider_q;
    logic                 switch_hold_q;
    logic                 secondary_osc_power_q;
    logic [3:0]           freq_code_q;
    logic [5:0]           trim_q;
    logic [OSTC_NRDY-1:0] rdy_meta_q;
    logic [OSTC_NRDY-1:0] rdy_sync_q;
    logic                 init_q;
    ostc_state_t          state_q;
    logic                 new_osc_ready_q;
    logic                 switch_event_q;
    logic                 req_rdy;
    logic                 osc_ready;
    logic                 aw_q;
    logic                 w_q;
    logic [7:0]           awaddr_q;
    logic [31:0]          wdata_q;
    logic [3:0]           wstrb_q;
    logic                 wr_go;
    logic                 bvalid_q;
    logic [1:0]           bresp_q;
    logic                 rvalid_q;
    logic [31:0]          rdata_q;
    logic [1:0]           rresp_q;
    logic [31:0]          rd_d;
    logic                 rd_ok;
    logic                 wr_ok;
    logic [2:0]           strap_src;
    logic [3:0]           strap_div;

    // Two-stage synchroniser per ready line
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdy_meta_q <= '0;
            rdy_sync_q <= '0;
        end else begin
            rdy_meta_q <= osc_ready_raw;
            rdy_sync_q <= rdy_meta_q;
        end
    end

    // Ready of the oscillator selected by the request
    always_comb begin
        unique case (requested_source_q)
            OSTC_SRC_EXT:    req_rdy = rdy_sync_q[7];
            OSTC_SRC_HF:     req_rdy = rdy_sync_q[6];
            OSTC_SRC_LF:     req_rdy = rdy_sync_q[4];
            OSTC_SRC_SEC:    req_rdy = rdy_sync_q[3];
            OSTC_SRC_EXTPLL: req_rdy = rdy_sync_q[0];
            default:         req_rdy = 1'b0;
        endcase
    end

    assign osc_ready = (requested_source_q == current_source_q) &&
                       (requested_divider_q == current_divider_q);

    // Writes land one cycle after both halves arrive
    assign wr_go = aw_q && w_q && !bvalid_q;
    assign wr_ok = (awaddr_q[1:0] == 2'b00) && wstrb_q[0];

    // Source/divider defaults from reset code; strap caught in the first cycle after reset release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            init_q <= 1'b1;
        end else begin
            init_q <= 1'b0;
        end
    end

    // Strap decode shared by request and current so both start equal
    always_comb begin
        strap_src = OSTC_SRC_HF;
        strap_div = OSTC_DIV_1;
        unique case (reset_source_code)
            OSTC_SRC_HF: begin
                strap_src = OSTC_SRC_HF;
                strap_div = OSTC_DIV_4;
            end
            OSTC_SRC_EXT, OSTC_SRC_LF, OSTC_SRC_SEC, OSTC_SRC_EXTPLL: begin
                strap_src = reset_source_code;
            end
            default: begin
                // Reserved codes fall back to HF 1:1; code 0 gets the 64 MHz frequency code, the others the 4 MHz code
                strap_src = OSTC_SRC_HF;
            end
        endcase
    end

    // Switch machine and current fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q           <= OSTC_IDLE;
            new_osc_ready_q   <= 1'b0;
            switch_event_q    <= 1'b0;
            current_source_q  <= OSTC_SRC_ZERO;
            current_divider_q <= OSTC_DIV_1;
        end else if (init_q) begin
            state_q           <= OSTC_IDLE;
            new_osc_ready_q   <= 1'b0;
            switch_event_q    <= 1'b0;
            current_source_q  <= strap_src;
            current_divider_q <= strap_div;
        end else begin
            switch_event_q <= 1'b0;
            unique case (state_q)
                OSTC_IDLE: begin
                    if (!osc_ready) begin
                        state_q <= OSTC_WAIT;
                    end
                end
                OSTC_WAIT: begin
                    if (osc_ready) begin
                        // Request abandoned by copying current back
                        state_q         <= OSTC_IDLE;
                        new_osc_ready_q <= 1'b0;
                    end else if (req_rdy) begin
                        if (!new_osc_ready_q) begin
                            switch_event_q <= 1'b1;
                        end
                        new_osc_ready_q <= 1'b1;
                        if (!switch_hold_q) begin
                            state_q <= OSTC_SWAP;
                        end
                    end else begin
                        new_osc_ready_q <= 1'b0;
                    end
                end
                OSTC_SWAP: begin
                    current_source_q  <= requested_source_q;
                    current_divider_q <= requested_divider_q;
                    new_osc_ready_q   <= 1'b0;
                    state_q           <= OSTC_IDLE;
                end
            endcase
        end
    end

    // Request fields: reserved codes leave both untouched
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            requested_source_q  <= OSTC_SRC_ZERO;
            requested_divider_q <= OSTC_DIV_1;
        end else if (init_q) begin
            requested_source_q  <= strap_src;
            requested_divider_q <= strap_div;
        end else if (wr_go && wr_ok && awaddr_q == OSTC_OFF_REQ) begin
            if ((wdata_q[6:4] == OSTC_SRC_EXT || wdata_q[6:4] == OSTC_SRC_HF ||
                 wdata_q[6:4] == OSTC_SRC_LF || wdata_q[6:4] == OSTC_SRC_SEC ||
                 wdata_q[6:4] == OSTC_SRC_EXTPLL) &&
                wdata_q[3:0] <= OSTC_DIV_MAX) begin
                requested_source_q  <= wdata_q[6:4];
                requested_divider_q <= wdata_q[3:0];
            end
        end
    end

    // Control bits; hardware clears hold on abandon
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            switch_hold_q         <= 1'b0;
            secondary_osc_power_q <= 1'b0;
        end else if (wr_go && wr_ok && awaddr_q == OSTC_OFF_CTRL) begin
            switch_hold_q         <= wdata_q[OSTC_HOLD_BIT];
            secondary_osc_power_q <= wdata_q[OSTC_PWR_BIT];
        end else if (state_q == OSTC_WAIT && osc_ready) begin
            switch_hold_q <= 1'b0;
        end
    end

    // Frequency select and trim
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            freq_code_q <= OSTC_FRQ_64M;
            trim_q      <= OSTC_TRIM_RST;
        end else if (init_q) begin
            freq_code_q <= (reset_source_code == OSTC_SRC_ZERO) ?
                           OSTC_FRQ_64M : OSTC_FRQ_4M;
        end else if (wr_go && wr_ok) begin
            if (awaddr_q == OSTC_OFF_FREQ && wdata_q[3:0] <= OSTC_FRQ_MAX) begin
                freq_code_q <= wdata_q[3:0];
            end
            if (awaddr_q == OSTC_OFF_TRIM) begin
                trim_q <= wdata_q[5:0];
            end
        end
    end

    // AXI write channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q  <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q     <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q     <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_q     <= 1'b0;
                w_q      <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= (awaddr_q <= OSTC_OFF_TRIM && awaddr_q[1:0] == 2'b00) ?
                            2'h0 : 2'h2;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read mux; unused bits zero
    always_comb begin
        rd_d  = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            OSTC_OFF_REQ:    rd_d[6:0] = {requested_source_q, requested_divider_q};
            OSTC_OFF_STATUS: rd_d[6:0] = {current_source_q, current_divider_q};
            OSTC_OFF_CTRL:   rd_d[7:0] = {switch_hold_q, secondary_osc_power_q, 1'b0,
                                          osc_ready, new_osc_ready_q, 3'h0};
            OSTC_OFF_READY:  rd_d[7:0] = {rdy_sync_q[7:2], 1'b0, rdy_sync_q[0]};
            OSTC_OFF_FREQ:   rd_d[3:0] = freq_code_q;
            OSTC_OFF_TRIM:   rd_d[5:0] = trim_q;
            default:         rd_ok     = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_d;
            rresp_q  <= rd_ok ? 2'h0 : 2'h2;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Ready outputs registered so they come from flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_q && !(s_axi_awvalid && s_axi_awready) && !bvalid_q;
            s_axi_wready  <= !w_q && !(s_axi_wvalid && s_axi_wready) && !bvalid_q;
            s_axi_arready <= !rvalid_q && !(s_axi_arvalid && s_axi_arready);
        end
    end

    assign s_axi_bvalid        = bvalid_q;
    assign s_axi_bresp         = bresp_q;
    assign s_axi_rvalid        = rvalid_q;
    assign s_axi_rdata         = rdata_q;
    assign s_axi_rresp         = rresp_q;
    assign switch_event        = switch_event_q;
    assign secondary_osc_power = secondary_osc_power_q;
    assign current_source      = current_source_q;
    assign current_divider     = current_divider_q;
    assign internal_freq_code  = freq_code_q;
    assign trim_code           = trim_q;

    AST_HOLD_BLOCKS: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == OSTC_WAIT && switch_hold_q && !osc_ready) |=> state_q != OSTC_SWAP)
        else $error("switch proceeded under hold");
    AST_SWITCH_NEXT: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == OSTC_SWAP) |=> (osc_ready && !new_osc_ready_q))
        else $error("switch did not complete");
    AST_NRDY_ONLY_SWITCH: assert property (@(posedge aclk) disable iff (!aresetn)
        new_osc_ready_q |-> !osc_ready || state_q == OSTC_SWAP || $past(osc_ready) == 0)
        else $error("new ready outside switch");
    AST_CUR_STABLE: assert property (@(posedge aclk) disable iff (!aresetn || init_q)
        (state_q != OSTC_SWAP && !init_q) |=> $stable(current_source_q))
        else $error("current source changed early");
    AST_CUR_DIV_STABLE: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q != OSTC_SWAP && !init_q) |=> $stable(current_divider_q))
        else $error("current divider changed early");
    AST_HOLD_RESET: assert property (@(posedge aclk) $rose(aresetn) |-> !switch_hold_q)
        else $error("hold not zero after reset");
    AST_SYNC_TWO: assert property (@(posedge aclk) disable iff (!aresetn)
        rdy_sync_q[6] == $past(osc_ready_raw[6], 2) || !$past(aresetn, 1) ||
        !$past(aresetn, 2))
        else $error("ready not two-stage");
    AST_DIV_LEGAL: assert property (@(posedge aclk) disable iff (!aresetn)
        requested_divider_q <= OSTC_DIV_MAX)
        else $error("reserved divider stored");
    AST_FRQ_LEGAL: assert property (@(posedge aclk) disable iff (!aresetn)
        freq_code_q <= OSTC_FRQ_MAX)
        else $error("reserved frequency stored");
    AST_INIT_MATCH: assert property (@(posedge aclk) disable iff (!aresetn)
        init_q |=> (osc_ready && state_q == OSTC_IDLE))
        else $error("start fields differ");
    AST_EVENT_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
        switch_event_q |=> !switch_event_q)
        else $error("switch event longer than a cycle");
    COV_SWITCH: cover property (@(posedge aclk) disable iff (!aresetn)
        state_q == OSTC_WAIT ##1 state_q == OSTC_SWAP);
    COV_HOLD: cover property (@(posedge aclk) disable iff (!aresetn)
        switch_hold_q && new_osc_ready_q);
    COV_READ: cover property (@(posedge aclk) disable iff (!aresetn) rvalid_q && s_axi_rready);
    COV_ABANDON: cover property (@(posedge aclk) disable iff (!aresetn)
        state_q == OSTC_WAIT && osc_ready);
endmodule : ostc_top
`default_nettype wire

/* ostc_bench.sv */
// Self-checking bench for the oscillator status and tuning block
`timescale 1ns/100ps
`default_nettype none
module ostc_bench;
    import ostc_pkg::*;
    typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} ostc_exp_t;
    logic                 aclk;
    logic                 aresetn;
    logic [2:0]           reset_source_code;
    logic [OSTC_NRDY-1:0] osc_ready_raw;
    logic                 awvalid, awready, wvalid, wready, bvalid, bready;
    logic                 arvalid, arready, rvalid, rready;
    logic [7:0]           awaddr, araddr;
    logic [31:0]          wdata, rdata;
    logic [3:0]           wstrb;
    logic [1:0]           bresp, rresp;
    logic                 switch_event, secondary_osc_power;
    logic [2:0]           current_source;
    logic [3:0]           current_divider, internal_freq_code;
    logic [5:0]           trim_code;
    int                   bad_count, comparisons, ev_cnt, cyc, ev0;
    logic [31:0]          seed, v;
    ostc_exp_t            rd_q[$];
    logic [1:0]           wr_q[$];
    ostc_top u_ostc_top (.aclk(aclk), .aresetn(aresetn), .reset_source_code(reset_source_code),
        .osc_ready_raw(osc_ready_raw), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .switch_event(switch_event), .secondary_osc_power(secondary_osc_power),
        .current_source(current_source), .current_divider(current_divider),
        .internal_freq_code(internal_freq_code), .trim_code(trim_code));
    always #5 aclk = ~aclk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict
    task automatic do_reset(input logic [2:0] code);
        @(posedge aclk);
        aresetn           <= 1'b0;
        reset_source_code <= code;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask : do_reset
    // Address and data offered together, released one by one as taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r);
        bit aw_done;
        bit w_done;
        wr_q.push_back(r);
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= d;
        wstrb   <= s;
        bready  <= 1'b1;
        aw_done = 0;
        w_done  = 0;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_done = 1;
            end
            if (!w_done && wready === 1'b1) begin
                wvalid <= 1'b0;
                w_done = 1;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic [1:0] r);
        rd_q.push_back('{d: d, m: m, r: r});
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    task automatic wait_src(input logic [2:0] s);
        int n;
        n = 0;
        while (current_source !== s && n < 60) begin
            @(posedge aclk);
            n++;
        end
        check("current_source", {29'h0, current_source}, {29'h0, s});
    endtask : wait_src
    // Monitor takes the oldest expectation whenever an answer is handed over
    always @(posedge aclk) begin
        ostc_exp_t e;
        if (rvalid === 1'b1 && rready === 1'b1 && rd_q.size() > 0) begin
            e = rd_q.pop_front();
            check("rdata", rdata & e.m, e.d & e.m);
            check("rresp", {30'h0, rresp}, {30'h0, e.r});
        end
        if (bvalid === 1'b1 && bready === 1'b1 && wr_q.size() > 0)
            check("bresp", {30'h0, bresp}, {30'h0, wr_q.pop_front()});
        if (switch_event === 1'b1)
            ev_cnt++;
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        logic [2:0] c;
        logic [2:0] src;
        logic [3:0] dv;
        logic [3:0] fq;
        logic [2:0] codes [6];
        logic [7:0] trims [3];
        aclk = 0; aresetn = 0; reset_source_code = 3'h6; osc_ready_raw = 8'hFF;
        awvalid = 0; awaddr = 8'h00; wvalid = 0; wdata = 32'h0; wstrb = 4'hF; bready = 0;
        arvalid = 0; araddr = 8'h00; rready = 0; seed = 32'h29; bad_count = 0;
        comparisons = 0; ev_cnt = 0; cyc = 0;
        // Every documented strap code, last one leaves HF 1:1
        codes = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h0};
        foreach (codes[i]) begin
            c   = codes[i];
            src = (c == 3'h0) ? OSTC_SRC_HF : c;
            dv  = (c == 3'h6) ? OSTC_DIV_4 : OSTC_DIV_1;
            fq  = (c == 3'h0) ? OSTC_FRQ_64M : OSTC_FRQ_4M;
            do_reset(c);
            rd(OSTC_OFF_STATUS, {25'h0, src, dv}, 32'hFFFFFFFF, 2'b00);
            rd(OSTC_OFF_REQ, {25'h0, src, dv}, 32'hFFFFFFFF, 2'b00);
            rd(OSTC_OFF_FREQ, {28'h0, fq}, 32'hFFFFFFFF, 2'b00);
            rd(OSTC_OFF_CTRL, 32'h10, 32'hFFFFFFFF, 2'b00);
            rd(OSTC_OFF_TRIM, 32'h0, 32'hFFFFFFFF, 2'b00);
        end
        // Ready levels pass the synchroniser; bit 1 never shows
        repeat (3) begin
            seed = xs(seed);
            @(posedge aclk);
            osc_ready_raw <= seed[7:0];
            repeat (4) @(posedge aclk);
            rd(OSTC_OFF_READY, {24'h0, seed[7:0] & 8'hFD}, 32'hFFFFFFFF, 2'b00);
        end
        // Trim codes either side of mid-scale and a random code; upper bits must not stick
        seed = xs(seed);
        trims = '{8'hDF, 8'h60, 8'hC0};
        foreach (trims[i]) begin
            v = {24'h0, trims[i]} ^ {26'h0, seed[5:0] & {6{i == 2}}};
            wr(OSTC_OFF_TRIM, v, 4'hF, 2'b00);
            check("trim_code", {26'h0, trim_code}, v & 32'h3F);
            rd(OSTC_OFF_TRIM, v & 32'h3F, 32'hFFFFFFFF, 2'b00);
        end
        wr(OSTC_OFF_TRIM, 32'h05, 4'h0, 2'b00);
        rd(OSTC_OFF_TRIM, v & 32'h3F, 32'hFFFFFFFF, 2'b00);
        fq = 4'(seed[15:8] % 9);
        wr(OSTC_OFF_FREQ, {28'h0, fq}, 4'hF, 2'b00);
        wr(OSTC_OFF_FREQ, 32'h09, 4'hF, 2'b00);
        check("freq_code", {28'h0, internal_freq_code}, {28'h0, fq});
        rd(OSTC_OFF_FREQ, {28'h0, fq}, 32'hFFFFFFFF, 2'b00);
        // Power bit and the holes around it
        wr(OSTC_OFF_CTRL, 32'hFF, 4'hF, 2'b00);
        check("secondary_power", {31'h0, secondary_osc_power}, 32'h1);
        rd(OSTC_OFF_CTRL, 32'hD0, 32'hFFFFFFFF, 2'b00);
        wr(OSTC_OFF_CTRL, 32'h80, 4'hF, 2'b00);
        // Held switch to the secondary oscillator while it is not ready
        @(posedge aclk);
        osc_ready_raw <= 8'hF7;
        repeat (4) @(posedge aclk);
        ev0 = ev_cnt;
        wr(OSTC_OFF_REQ, {25'h0, OSTC_SRC_SEC, OSTC_DIV_1}, 4'hF, 2'b00);
        rd(OSTC_OFF_CTRL, 32'h80, 32'hFFFFFFFF, 2'b00);
        rd(OSTC_OFF_STATUS, {25'h0, OSTC_SRC_HF, OSTC_DIV_1}, 32'hFFFFFFFF, 2'b00);
        osc_ready_raw <= 8'hFF;
        repeat (8) @(posedge aclk);
        rd(OSTC_OFF_CTRL, 32'h88, 32'hFFFFFFFF, 2'b00);
        rd(OSTC_OFF_STATUS, {25'h0, OSTC_SRC_HF, OSTC_DIV_1}, 32'hFFFFFFFF, 2'b00);
        check("switch_events", ev_cnt, ev0 + 1);
        wr(OSTC_OFF_CTRL, 32'h00, 4'hF, 2'b00);
        wait_src(OSTC_SRC_SEC);
        rd(OSTC_OFF_STATUS, {25'h0, OSTC_SRC_SEC, OSTC_DIV_1}, 32'hFFFFFFFF, 2'b00);
        rd(OSTC_OFF_CTRL, 32'h10, 32'hFFFFFFFF, 2'b00);
        // Unheld switch with a ready source and the largest divider
        wr(OSTC_OFF_REQ, {25'h0, OSTC_SRC_LF, OSTC_DIV_MAX}, 4'hF, 2'b00);
        wait_src(OSTC_SRC_LF);
        check("current_divider", {28'h0, current_divider}, {28'h0, OSTC_DIV_MAX});
        rd(OSTC_OFF_CTRL, 32'h10, 32'hFFFFFFFF, 2'b00);
        check("switch_events", ev_cnt, ev0 + 2);
        // Reserved source and divider codes leave the request alone
        wr(OSTC_OFF_REQ, 32'h30, 4'hF, 2'b00);
        wr(OSTC_OFF_REQ, 32'h5A, 4'hF, 2'b00);
        rd(OSTC_OFF_REQ, {25'h0, OSTC_SRC_LF, OSTC_DIV_MAX}, 32'hFFFFFFFF, 2'b00);
        // Unmapped place
        wr(8'h18, 32'hFF, 4'hF, 2'b10);
        rd(8'h18, 32'h0, 32'h0, 2'b10);
        repeat (4) @(posedge aclk);
        print_verdict();
    end
endmodule : ostc_bench
`default_nettype wire
